/* hw/asm_brg.sv */
// bit-rate generator: prescaler or external clock, then divide by n+1
`timescale 1ns/10ps
module asm_brg (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // configuration
   input  wire logic [1:0] presc_sel,
   input  wire logic       ext_sel,
   input  wire logic [7:0] div,
   // external reference pin
   input  wire logic       ext_clock_pin,
   // sixteen-times bit clock enable
   output logic            tick16
);
   import asm_pkg::*;

   typedef struct packed {
      logic [4:0] pre_cnt;
      logic [7:0] div_cnt;
      logic       ck_s1;
      logic       ck_s2;
      logic       ck_prev;
      logic       tick;
   } asm_brg_s;

   asm_brg_s st_q;
   asm_brg_s st_d;
   logic     pre_hit;
   logic     src_en;

   always_comb begin
      st_d       = st_q;
      st_d.tick  = 1'b0;
      st_d.ck_s1 = ext_clock_pin;
      st_d.ck_s2 = st_q.ck_s1;
      st_d.ck_prev = st_q.ck_s2;
      case (presc_sel)
         2'h0:    pre_hit = 1'b1;
         2'h1:    pre_hit = (st_q.pre_cnt >= PRE_F8_LAST);
         default: pre_hit = (st_q.pre_cnt >= PRE_F32_LAST);
      endcase
      st_d.pre_cnt = pre_hit ? 5'h00 : st_q.pre_cnt + 5'h01;
      // external reference counts rising edges of the clock pin
      src_en = ext_sel ? (st_q.ck_s2 & ~st_q.ck_prev) : pre_hit; // R04
      if (src_en) begin
         if (st_q.div_cnt == 8'h00) begin
            st_d.div_cnt = div; // R03
            st_d.tick    = 1'b1; // R02
         end else begin
            st_d.div_cnt = st_q.div_cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick16 = st_q.tick;
endmodule // asm_brg

/* hw/asm_channel.sv */
// one asynchronous serial channel with register port and pin control
//
// Contract
// R01: frame is start, 7/8/9 character bits, optional parity, one or two stops.
// R02: bit rate is source clock over sixteen times divider plus one.
// R03: divider setting is an eight-bit value zero to 255.
// R04: external source takes reference from the channel clock pin.
// R05: overrun overwrites receive buffer and raises no receive request.
// R06: flag overrun, framing, parity errors and an error-sum flag.
// R07: transmit starts only when enabled, buffer full and clear-to-send low.
// R08: serial output idles high, or floats with open-drain, until transfer.
// R09: serial input is data only when its direction bit is zero.
// R10: clock pin is external clock only when selected; channel c never.
// R11: flow pin is clear-to-send, request-to-send or general by two bits.
// R12: channel a may route request-to-send to a separate pin.
// R13: software clears channel b flow bits when separate pins are used.
// R14: in sleep mode only characters with msb one are accepted; channel c ignores the sleep bit and accepts all.
// R15: channel c data-logic bit inverts character bits on buffer access.
// R16: inversion never touches start, parity or stop bits.
// R17: channel c polarity reverse inverts whole serial output and input.
// R18: channel c compares output and input levels; mismatch raises request.
// R19: receiver finds start edge and samples bits at their centre.
// R20: rejected sleep characters leave buffer and request untouched.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module asm_channel #(
   parameter logic [1:0] CHAN = asm_pkg::CHAN_A
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [4:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // serial pins
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe,
   input  wire logic        serial_in_pin,
   input  wire logic        ext_clock_pin,
   // flow-control pins
   input  wire logic        flow_pin_i,
   output logic             flow_pin_o,
   output logic             flow_pin_oe,
   output logic             flow_alt_pin_o,
   output logic             flow_alt_pin_oe,
   // request pulses
   output logic             rx_req,
   output logic             tx_req,
   output logic             col_req
);
   import asm_pkg::*;

   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  brg;
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [8:0]  txbuf;
      logic        txbuf_full;
      logic [8:0]  txsh;
      asm_tx_e     tx_st;
      logic [3:0]  tx_cnt;
      logic [3:0]  tx_bit;
      logic        tx_par;
      logic        tx_line;
      logic [8:0]  rxbuf;
      logic        rx_full;
      logic        ovr;
      logic        fer;
      logic        per;
      logic        col;
      asm_rx_e     rx_st;
      logic [3:0]  rx_cnt;
      logic [3:0]  rx_bit;
      logic [8:0]  rxsh;
      logic        rx_par;
      logic        rx_ferr;
      logic        rx_prev;
      logic        rx_s1;
      logic        rx_s2;
      logic        cts_s1;
      logic        cts_s2;
      logic [31:0] rdata;
      logic        out;
      logic        oe;
      logic        fl_o;
      logic        fl_oe;
      logic        fa_o;
      logic        fa_oe;
      logic        rx_req;
      logic        tx_req;
      logic        col_req;
   } asm_state_s;

   asm_state_s st_q;
   asm_state_s st_d;
   logic       tk;
   logic       brg_ext;
   logic       rev;
   logic       rxl;
   logic       cts_ok;
   logic       rx_fin;
   logic       rx_keep;
   logic [3:0] nb;
   logic [8:0] msk;
   logic [8:0] inv;
   logic       lvl;
   logic       rts_on;

   // number of character bits
   function automatic logic [3:0] nbits(input logic [1:0] len);
      case (len)
         LEN_7:   nbits = 4'h7;
         LEN_9:   nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   endfunction

   // mask of the character bits
   function automatic logic [8:0] cmask(input logic [1:0] len);
      case (len)
         LEN_7:   cmask = 9'h07f;
         LEN_9:   cmask = 9'h1ff;
         default: cmask = 9'h0ff;
      endcase
   endfunction

   // parity bit for the character, even or odd
   function automatic logic parity(input logic [8:0] d, input logic [8:0] m,
                                   input logic odd);
      parity = (^(d & m)) ^ odd;
   endfunction

   assign brg_ext = st_q.mode[MODE_EXT] && (CHAN != CHAN_C); // R10 R04

   asm_brg u_brg (
      .core_clk      (core_clk),
      .nrst          (nrst),
      .presc_sel     (st_q.ctl0[CTL0_PRE +: 2]),
      .ext_sel       (brg_ext),
      .div           (st_q.brg),
      .ext_clock_pin (ext_clock_pin),
      .tick16        (tk)
   );

   always_comb begin
      st_d         = st_q;
      st_d.rx_req  = 1'b0;
      st_d.tx_req  = 1'b0;
      st_d.col_req = 1'b0;
      st_d.rdata   = 32'h0000_0000;
      rx_fin       = 1'b0;
      rx_keep      = 1'b0;
      nb           = nbits(st_q.mode[MODE_LEN +: 2]); // R01
      msk          = cmask(st_q.mode[MODE_LEN +: 2]);
      inv          = (CHAN == CHAN_C && st_q.ctl1[CTL1_DINV]) ? msk : 9'h000; // R15 R16
      rev          = (CHAN == CHAN_C) && st_q.ctl1[CTL1_REV];
      // synchronisers
      st_d.rx_s1   = serial_in_pin;
      st_d.rx_s2   = st_q.rx_s1;
      st_d.cts_s1  = flow_pin_i;
      st_d.cts_s2  = st_q.cts_s1;
      rxl          = (st_q.rx_s2 ^ rev) | st_q.ctl0[CTL0_RXDIR]; // R17 R09
      st_d.rx_prev = rxl;
      cts_ok       = st_q.ctl0[CTL0_FDIS] | st_q.ctl0[CTL0_FUNC] | ~st_q.cts_s2; // R11

      // status flag clear, write one to clear; later sets win, and any accepted character keeps the old framing flag
      if (wr && addr == ADDR_STAT) begin
         st_d.ovr = st_q.ovr & ~wdata[3];
         st_d.fer = st_q.fer & ~wdata[4];
         st_d.per = st_q.per & ~wdata[5];
         st_d.col = st_q.col & ~wdata[7];
      end

      // transmitter
      if (st_q.tx_st == T_IDLE) begin
         st_d.tx_line = 1'b1; // R08
         if (st_q.ctl1[CTL1_TXEN] && st_q.txbuf_full && cts_ok) begin // R07
            st_d.txsh       = st_q.txbuf;
            st_d.tx_par     = parity(st_q.txbuf, msk, st_q.mode[MODE_ODD]);
            st_d.txbuf_full = 1'b0;
            st_d.tx_req     = 1'b1;
            st_d.tx_st      = T_START;
            st_d.tx_cnt     = 4'h0;
            st_d.tx_line    = 1'b0;
         end
      end else if (tk) begin
         st_d.tx_cnt = st_q.tx_cnt + 4'h1;
         // collision check in the middle of each bit
         if (CHAN == CHAN_C && st_q.ctl1[CTL1_COLEN] && st_q.tx_cnt == OVS_MID &&
             ((st_q.tx_line ^ rev) != st_q.rx_s2)) begin
            st_d.col     = 1'b1; // R18
            st_d.col_req = 1'b1; // R18
         end
         if (st_q.tx_cnt == OVS_LAST) begin
            case (st_q.tx_st)
               T_START: begin
                  st_d.tx_st   = T_DATA;
                  st_d.tx_bit  = 4'h0;
                  st_d.tx_line = st_q.txsh[0];
               end
               T_DATA: begin
                  st_d.txsh   = {1'b0, st_q.txsh[8:1]};
                  st_d.tx_bit = st_q.tx_bit + 4'h1;
                  if (st_q.tx_bit == nb - 4'h1 + {3'h0, st_q.mode[MODE_PEN]}) begin
                     st_d.tx_st   = T_STOP; // R01
                     st_d.tx_bit  = 4'h0;
                     st_d.tx_line = 1'b1;
                  end else if (st_q.tx_bit == nb - 4'h1) begin
                     st_d.tx_line = st_q.tx_par; // R01
                  end else begin
                     st_d.tx_line = st_q.txsh[1];
                  end
               end
               default: begin
                  if (st_q.mode[MODE_STOP2] && st_q.tx_bit == 4'h0) begin
                     st_d.tx_bit = 4'h1; // R01
                  end else begin
                     st_d.tx_st = T_IDLE;
                  end
               end
            endcase
         end
      end

      // receiver
      case (st_q.rx_st)
         R_IDLE: begin
            if (st_q.ctl1[CTL1_RXEN] && st_q.rx_prev && !rxl) begin
               st_d.rx_st   = R_START; // R19
               st_d.rx_cnt  = 4'h0;
               st_d.rx_ferr = 1'b0;
               st_d.rxsh    = 9'h000;
            end
         end
         R_START: begin
            if (tk) begin
               st_d.rx_cnt = st_q.rx_cnt + 4'h1;
               if (st_q.rx_cnt == OVS_MID) begin
                  st_d.rx_cnt = 4'h0;
                  st_d.rx_bit = 4'h0;
                  st_d.rx_st  = rxl ? R_IDLE : R_DATA; // R19
               end
            end
         end
         default: begin
            if (tk) begin
               st_d.rx_cnt = st_q.rx_cnt + 4'h1;
               if (st_q.rx_cnt == OVS_LAST) begin
                  if (st_q.rx_st == R_DATA) begin
                     st_d.rxsh[st_q.rx_bit] = rxl; // R19
                     st_d.rx_bit = st_q.rx_bit + 4'h1;
                     if (st_q.rx_bit == nb - 4'h1) begin
                        st_d.rx_bit = 4'h0;
                        st_d.rx_st  = st_q.mode[MODE_PEN] ? R_PAR : R_STOP;
                     end
                  end else if (st_q.rx_st == R_PAR) begin
                     st_d.rx_par = rxl;
                     st_d.rx_st  = R_STOP;
                  end else begin
                     st_d.rx_ferr = st_q.rx_ferr | ~rxl;
                     if (st_q.mode[MODE_STOP2] && st_q.rx_bit == 4'h0) begin
                        st_d.rx_bit = 4'h1;
                     end else begin
                        st_d.rx_st = R_IDLE;
                        rx_fin     = 1'b1;
                     end
                  end
               end
            end
         end
      endcase

      // character completion
      rx_keep = !(CHAN != CHAN_C && st_q.mode[MODE_SLEEP] &&
                  !st_q.rxsh[nb - 4'h1]); // R14
      if (rx_fin && rx_keep) begin // R20
         st_d.rxbuf = st_q.rxsh & msk;
         if (st_q.rx_full) begin
            st_d.ovr = 1'b1; // R05
         end else begin
            st_d.rx_req = 1'b1;
         end
         st_d.fer = st_q.fer | st_d.rx_ferr; // R06
         if (st_q.mode[MODE_PEN] &&
             parity(st_q.rxsh, msk, st_q.mode[MODE_ODD]) != st_q.rx_par) begin
            st_d.per = 1'b1; // R06
         end
      end

      // register writes
      if (wr) begin
         if (addr == ADDR_MODE) begin
            st_d.mode = wdata[7:0];
         end else if (addr == ADDR_BRG) begin
            st_d.brg = wdata[7:0]; // R03
         end else if (addr == ADDR_CTL0) begin
            st_d.ctl0 = wdata[7:0];
         end else if (addr == ADDR_CTL1) begin
            st_d.ctl1 = wdata[7:0];
         end else if (addr == ADDR_TXBUF) begin
            st_d.txbuf      = (wdata[8:0] ^ inv) & msk; // R15
            st_d.txbuf_full = 1'b1;
         end
      end

      // register reads, data one cycle later
      if (rd) begin
         if (addr == ADDR_MODE) begin
            st_d.rdata = {24'h000000, st_q.mode};
         end else if (addr == ADDR_BRG) begin
            st_d.rdata = {24'h000000, st_q.brg};
         end else if (addr == ADDR_CTL0) begin
            st_d.rdata = {24'h000000, st_q.ctl0};
         end else if (addr == ADDR_CTL1) begin
            st_d.rdata = {24'h000000, st_q.ctl1};
         end else if (addr == ADDR_RXBUF) begin
            st_d.rdata = {23'h0, st_q.rxbuf ^ inv}; // R15
         end else if (addr == ADDR_STAT) begin
            st_d.rdata = {24'h000000, st_q.col, st_q.ovr | st_q.fer | st_q.per, // R06
                          st_q.per, st_q.fer, st_q.ovr, st_q.rx_full,
                          st_q.tx_st == T_IDLE, ~st_q.txbuf_full};
         end
      end
      // reading the buffer empties it; a new character in the same cycle wins
      if (rd && addr == ADDR_RXBUF) begin
         st_d.rx_full = 1'b0;
      end
      if (rx_fin && rx_keep) begin
         st_d.rx_full = 1'b1;
      end

      // serial output pin
      lvl       = st_d.tx_line ^ rev; // R17
      st_d.out  = lvl;
      st_d.oe   = st_q.ctl0[CTL0_OD] ? ~lvl : 1'b1; // R08
      // flow-control pins, request-to-send is active low
      rts_on    = !st_q.ctl0[CTL0_FDIS] && st_q.ctl0[CTL0_FUNC];
      st_d.fl_o  = ~(st_q.ctl1[CTL1_RXEN] & ~st_d.rx_full);
      st_d.fa_o  = st_d.fl_o;
      st_d.fl_oe = 1'b0;
      st_d.fa_oe = 1'b0;
      if (rts_on) begin
         if (CHAN == CHAN_A && st_q.ctl0[CTL0_SEP]) begin
            st_d.fa_oe = 1'b1; // R12
         end else begin
            st_d.fl_oe = 1'b1; // R11
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q         <= '0;
         st_q.mode    <= MODE_RST;
         st_q.brg     <= BRG_RST;
         st_q.ctl0    <= CTL0_RST;
         st_q.ctl1    <= CTL1_RST;
         st_q.tx_line <= 1'b1;
         st_q.rx_prev <= 1'b1;
         st_q.rx_s1   <= 1'b1;
         st_q.rx_s2   <= 1'b1;
         st_q.cts_s1  <= 1'b1;
         st_q.cts_s2  <= 1'b1;
         st_q.out     <= 1'b1;
         st_q.oe      <= 1'b1;
         st_q.fl_o    <= 1'b1;
         st_q.fa_o    <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata             = st_q.rdata;
   assign serial_out_pin_o  = st_q.out;
   assign serial_out_pin_oe = st_q.oe;
   assign flow_pin_o        = st_q.fl_o;
   assign flow_pin_oe       = st_q.fl_oe;
   assign flow_alt_pin_o    = st_q.fa_o;
   assign flow_alt_pin_oe   = st_q.fa_oe;
   assign rx_req            = st_q.rx_req;
   assign tx_req            = st_q.tx_req;
   assign col_req           = st_q.col_req;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   tx_start_a: assert property ( // R07
      (st_q.tx_st == T_IDLE && st_d.tx_st == T_START) |->
      (st_q.ctl1[CTL1_TXEN] && st_q.txbuf_full && cts_ok))
      else $error("transmit started without its conditions");
   idle_high_a: assert property ( // R08
      (st_q.tx_st == T_IDLE && !st_q.ctl0[CTL0_OD] && !rev)[*2] |->
      (serial_out_pin_o && serial_out_pin_oe))
      else $error("serial output not high while idle");
   ovr_noreq_a: assert property ( // R05
      (rx_fin && rx_keep && st_q.rx_full) |=> (!rx_req && st_q.ovr && st_q.rx_full))
      else $error("overrun raised a receive request");
   sleep_drop_a: assert property ( // R20
      (rx_fin && !rx_keep) |=> (!rx_req && st_q.rxbuf == $past(st_q.rxbuf)))
      else $error("rejected sleep character changed the buffer");
   err_sum_a: assert property ( // R06
      (rd && addr == ADDR_STAT) |=> (rdata[6] == (rdata[3] | rdata[4] | rdata[5])))
      else $error("error sum flag disagrees with error flags");
   col_chan_a: assert property ( // R18
      col_req |-> (CHAN == CHAN_C && $past(st_q.ctl1[CTL1_COLEN])))
      else $error("collision request without detection enabled");
   ext_clock_a: assert property ((CHAN == CHAN_C) |-> !brg_ext) // R10
      else $error("external clock used on channel c");
   rts_level_a: assert property ( // R11
      (!st_q.ctl0[CTL0_FDIS] && st_q.ctl0[CTL0_FUNC] && !st_q.ctl0[CTL0_SEP]) ##1
      (st_q.ctl0 == $past(st_q.ctl0)) |->
      (flow_pin_oe && flow_pin_o == !($past(st_q.ctl1[CTL1_RXEN]) && !st_q.rx_full)))
      else $error("request-to-send pin wrong");
   rx_req_full_a: assert property (rx_req |-> (st_q.rx_full && $past(rx_fin, 1))) // R14
      else $error("receive request without accepted character");
endmodule // asm_channel

/* hw/asm_pkg.sv */
// shared constants and types of the asynchronous serial channel
package asm_pkg;
   // register byte addresses
   localparam logic [4:0] ADDR_MODE  = 5'h00;
   localparam logic [4:0] ADDR_BRG   = 5'h04;
   localparam logic [4:0] ADDR_CTL0  = 5'h08;
   localparam logic [4:0] ADDR_CTL1  = 5'h0c;
   localparam logic [4:0] ADDR_TXBUF = 5'h10;
   localparam logic [4:0] ADDR_RXBUF = 5'h14;
   localparam logic [4:0] ADDR_STAT  = 5'h18;
   // mode register fields
   localparam int MODE_LEN   = 0;
   localparam int MODE_EXT   = 3;
   localparam int MODE_STOP2 = 4;
   localparam int MODE_ODD   = 5;
   localparam int MODE_PEN   = 6;
   localparam int MODE_SLEEP = 7;
   // control 0 fields
   localparam int CTL0_PRE   = 0;
   localparam int CTL0_FUNC  = 2;
   localparam int CTL0_OD    = 3;
   localparam int CTL0_FDIS  = 4;
   localparam int CTL0_SEP   = 6;
   localparam int CTL0_RXDIR = 7;
   // control 1 fields
   localparam int CTL1_TXEN  = 0;
   localparam int CTL1_RXEN  = 2;
   localparam int CTL1_REV   = 3;
   localparam int CTL1_COLEN = 5;
   localparam int CTL1_DINV  = 6;
   // reset values
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] BRG_RST  = 8'h00;
   localparam logic [7:0] CTL0_RST = 8'h10;
   localparam logic [7:0] CTL1_RST = 8'h00;
   // character length codes
   localparam logic [1:0] LEN_7 = 2'h0;
   localparam logic [1:0] LEN_8 = 2'h1;
   localparam logic [1:0] LEN_9 = 2'h2;
   // prescaler and oversampling counts
   localparam logic [4:0] PRE_F8_LAST  = 5'h07;
   localparam logic [4:0] PRE_F32_LAST = 5'h1f;
   localparam logic [3:0] OVS_LAST     = 4'hf;
   localparam logic [3:0] OVS_MID      = 4'h7;
   // channel kinds
   localparam logic [1:0] CHAN_A = 2'h0;
   localparam logic [1:0] CHAN_B = 2'h1;
   localparam logic [1:0] CHAN_C = 2'h2;

   typedef enum logic [1:0] {
      T_IDLE  = 2'b00,
      T_START = 2'b01,
      T_DATA  = 2'b10,
      T_STOP  = 2'b11
   } asm_tx_e;

   typedef enum logic [2:0] {
      R_IDLE  = 3'b000,
      R_START = 3'b001,
      R_DATA  = 3'b010,
      R_PAR   = 3'b011,
      R_STOP  = 3'b100
   } asm_rx_e;
endpackage

/* testbench/asm_channel_tb_top.sv */
// self-checking bench for asynchronous serial channels a and c on one bus
`timescale 1ns/10ps
module asm_channel_tb_top;
   import asm_pkg::*;
   logic        core_clk;
   logic        nrst;
   logic [4:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        tx_o;
   logic        tx_oe;
   logic        tx_line;
   logic        rx_line;
   logic        cts_n;
   logic        rx_req;
   logic        tx_req;
   logic [3:0]  flw;
   logic [31:0] rdata_c;
   logic        txc;
   logic        col_a;
   logic        col_c;
   logic        ext_ck = 1'b0;
   int          n_col;
   int          n_fail;
   int          check_count;
   int          n_rx;
   int          n_txr;
   int          cyc;
   logic [4:0]  ra [5] = '{ADDR_MODE, ADDR_BRG, ADDR_CTL0, ADDR_CTL1, 5'h1c};
   logic [7:0]  rv [5] = '{MODE_RST, BRG_RST, CTL0_RST, CTL1_RST, 8'h00};

   // released line is pulled up
   assign tx_line = tx_oe ? tx_o : 1'b1;

   asm_channel #(.CHAN(CHAN_A)) u_dut (
      .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_out_pin_o(tx_o), .serial_out_pin_oe(tx_oe),
      .serial_in_pin(rx_line), .ext_clock_pin(ext_ck), .flow_pin_i(cts_n),
      .flow_pin_o(flw[2]), .flow_pin_oe(flw[3]), .flow_alt_pin_o(flw[0]),
      .flow_alt_pin_oe(flw[1]), .rx_req(rx_req), .tx_req(tx_req), .col_req(col_a)
   );

   asm_channel #(.CHAN(CHAN_C)) u_dutc (
      .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata_c), .serial_out_pin_o(txc), .serial_out_pin_oe(),
      .serial_in_pin(rx_line), .ext_clock_pin(ext_ck), .flow_pin_i(cts_n),
      .flow_pin_o(), .flow_pin_oe(), .flow_alt_pin_o(), .flow_alt_pin_oe(),
      .rx_req(), .tx_req(), .col_req(col_c)
   );

   asm_remote u_rem (
      .core_clk(core_clk), .line_in(tx_line), .line_out(rx_line), .cts_n(cts_n)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (rx_req === 1'b1) n_rx++;
      if (tx_req === 1'b1) n_txr++;
      if (col_a === 1'b1 || col_c === 1'b1) n_col++;
      ext_ck <= ~ext_ck;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
      @(posedge core_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge core_clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
      @(posedge core_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic wait_got(input int n);
      for (int k = 0; k < 800 && u_rem.n_got != n; k++) @(posedge core_clk);
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      int          k;
      nrst  = 1'b0;
      addr  = 5'h00;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
      repeat (7) @(posedge core_clk);
      #1 chk("idle level", {30'h0, tx_oe, tx_o}, 32'h3);
      @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_reg(ra[i], d);
         chk("reset value", d, {24'h0, rv[i]});
      end
      wr_reg(ADDR_BRG, 32'hff);
      rd_reg(ADDR_BRG, d);
      chk("divider top", d, 32'hff);
      wr_reg(ADDR_BRG, 32'h0);
      // transmit held back by clear-to-send, then released
      wr_reg(ADDR_CTL0, 32'h00);
      wr_reg(ADDR_CTL1, 32'h05);
      wr_reg(ADDR_TXBUF, 32'h3c);
      repeat (300) @(posedge core_clk);
      chk("held by cts", u_rem.n_got + n_txr, 0);
      chk("line idle", {31'h0, tx_line}, 32'h1);
      u_rem.cts_n <= 1'b0;
      wait_got(1);
      chk("tx char", {24'h0, u_rem.got}, 32'h3c);
      chk("tx stop", {31'h0, u_rem.got_stop}, 32'h1);
      chk("tx req", n_txr, 1);
      // receive path
      wr_reg(ADDR_CTL0, 32'h10);
      u_rem.send(8'ha5, 1'b1);
      chk("rx req", n_rx, 1);
      rd_reg(ADDR_RXBUF, d);
      chk("rx char", d, 32'ha5);
      // overrun
      u_rem.send(8'h11, 1'b1);
      u_rem.send(8'h22, 1'b1);
      chk("ovr req", n_rx, 2);
      rd_reg(ADDR_STAT, d);
      chk("ovr flags", d & 32'h48, 32'h48);
      rd_reg(ADDR_RXBUF, d);
      chk("ovr char", d, 32'h22);
      wr_reg(ADDR_STAT, 32'hb8);
      // framing error
      u_rem.send(8'h5a, 1'b0);
      rd_reg(ADDR_STAT, d);
      chk("frame flags", d & 32'h58, 32'h50);
      rd_reg(ADDR_RXBUF, d);
      wr_reg(ADDR_STAT, 32'hb8);
      // sleep filtering
      k = n_rx;
      wr_reg(ADDR_MODE, 32'h81);
      u_rem.send(8'h33, 1'b1);
      chk("sleep drop", n_rx - k, 0);
      rd_reg(ADDR_RXBUF, d);
      chk("sleep keep", d, 32'h5a);
      u_rem.send(8'hb3, 1'b1);
      chk("sleep take", n_rx - k, 1);
      rd_reg(ADDR_RXBUF, d);
      chk("sleep char", d, 32'hb3);
      // input pin used as port
      wr_reg(ADDR_MODE, 32'h01);
      wr_reg(ADDR_CTL0, 32'h90);
      u_rem.send(8'h44, 1'b1);
      chk("port pin", n_rx - k, 1);
      // request-to-send on the flow pin, serial output released in open-drain
      wr_reg(ADDR_CTL0, 32'h0c);
      repeat (2) @(posedge core_clk);
      chk("rts pin", {28'h0, flw}, 32'h8);
      chk("open drain", {31'h0, tx_oe}, 32'h0);
      // separate pins; request-to-send moves to the alternate flow pin
      wr_reg(ADDR_CTL0, 32'h4c);
      repeat (2) @(posedge core_clk);
      chk("rts alt pin", {28'h0, flw}, 32'h2);
      // external reference ticks every two cycles; channel c keeps its prescaler
      wr_reg(ADDR_MODE, 32'h09);
      wr_reg(ADDR_TXBUF, 32'h00);
      repeat (250) @(posedge core_clk);
      rd_reg(ADDR_STAT, d);
      chk("ext slow", d & 32'h2, 32'h0);
      chk("c no ext", rdata_c & 32'h2, 32'h2);
      repeat (100) @(posedge core_clk);
      rd_reg(ADDR_STAT, d);
      chk("ext done", d & 32'h2, 32'h2);
      // line polarity reverse on channel c only
      wr_reg(ADDR_CTL1, 32'h08);
      repeat (2) @(posedge core_clk);
      chk("c reversed", {31'h0, txc}, 32'h0);
      chk("a plain", {31'h0, tx_line}, 32'h1);
      // collision: channel c start bit against an idle input line
      wr_reg(ADDR_MODE, 32'h01);
      wr_reg(ADDR_CTL1, 32'h25);
      wr_reg(ADDR_TXBUF, 32'hff);
      repeat (40) @(posedge core_clk);
      rd_reg(ADDR_STAT, d);
      chk("c collision", rdata_c & 32'h80, 32'h80);
      chk("a no collision", d & 32'h80, 32'h0);
      chk("col req", n_col, 1);
      // data-logic inversion on receive buffer read
      wr_reg(ADDR_CTL1, 32'h40);
      rd_reg(ADDR_RXBUF, d);
      chk("c inverted", rdata_c, 32'h4c);
      chk("a not inverted", d, 32'hb3);
      end_of_test();
   end
endmodule // asm_channel_tb_top

/* testbench/asm_remote.sv */
// remote serial peer: sends frames to the channel and captures frames from it
`timescale 1ns/10ps
module asm_remote #(
   parameter int BIT_CYC = 16
) (
   // clock
   input  wire logic core_clk,
   // line from the channel, line to it
   input  wire logic line_in,
   output logic      line_out,
   // clear-to-send towards the channel, active low
   output logic      cts_n
);
   logic [7:0] got;
   logic       got_stop;
   int         n_got;

   initial begin
      line_out = 1'b1;
      cts_n    = 1'b1;
      got      = 8'h00;
      got_stop = 1'b0;
      n_got    = 0;
   end

   // one frame: start, eight bits lsb first, one stop, one idle bit
   task automatic send(input logic [7:0] d, input logic stop_ok);
      @(posedge core_clk);
      line_out <= 1'b0;
      repeat (BIT_CYC) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         line_out <= d[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
      line_out <= stop_ok;
      repeat (BIT_CYC) @(posedge core_clk);
      line_out <= 1'b1;
      repeat (BIT_CYC) @(posedge core_clk);
   endtask

   // capture at bit centres
   initial begin
      forever begin
         @(negedge line_in);
         repeat (BIT_CYC / 2) @(posedge core_clk);
         if (line_in == 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYC) @(posedge core_clk);
               got[i] = line_in;
            end
            repeat (BIT_CYC) @(posedge core_clk);
            got_stop = line_in;
            n_got++;
         end
      end
   end
endmodule // asm_remote
